//--- hdl/trace_reg_access_permission_multi_power.sv
// Register file of a trace unit with access permissions for split power domains.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module trace_reg_access_permission_multi_power (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire trace_perm_pkg::power_ctx_t ctx_in,
   input wire trace_perm_pkg::path_t path_in,
   input wire trace_perm_pkg::addr_t addr_in,
   input wire trace_perm_pkg::data_t wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output trace_perm_pkg::data_t rdata_out,
   output trace_perm_pkg::outcome_t resp_out,
   output logic resp_valid_out,
   output trace_perm_pkg::access_state_t access_state_out,
   output trace_perm_pkg::data_t main_control_out,
   output logic sw_lock_out,
   output logic os_lock_out,
   output logic sticky_out
);
   import trace_perm_pkg::*;

   typedef struct packed {
      data_t main_control;
      data_t trace_data;
      data_t claim;
      logic sw_lock;
      logic os_lock;
      logic sticky;
      data_t rdata;
      outcome_t resp;
      access_state_t state;
      logic resp_valid;
   } regs_t;

   localparam regs_t REGS_RESET = '{
      main_control: MC_RESET,
      trace_data: '0,
      claim: '0,
      sw_lock: SW_LOCK_RESET,
      os_lock: OS_LOCK_RESET,
      sticky: STICKY_RESET,
      rdata: '0,
      resp: OUT_OK,
      state: ST_OTHERWISE,
      resp_valid: 1'b0
   };

   regs_t s_ff;
   regs_t nxt_s;
   group_t grp;
   access_state_t state;
   outcome_t outcome;
   logic wr_ok;
   logic rd_ok;
   logic pd_set;

   // ****************************************************************
   // Permission decode for the access on the bus.
   // ****************************************************************
   assign grp = addr_group(addr_in);

   access_perm_decode u_decode (
      .ctx_in(ctx_in),
      .path_in(path_in),
      .group_in(grp),
      .sticky_in(s_ff.sticky),
      .os_lock_in(s_ff.os_lock),
      .sw_lock_in(s_ff.sw_lock),
      .state_out(state),
      .outcome_out(outcome)
   );

   assign wr_ok = wr_in && (outcome == OUT_OK);
   assign rd_ok = rd_in && ((outcome == OUT_OK) || (outcome == OUT_WI));
   assign pd_set = s_ff.main_control[MC_PD_BIT];

   // ****************************************************************
   // Next state.
   // ****************************************************************
   always_comb begin
      nxt_s = s_ff;
      nxt_s.resp_valid = rd_in || wr_in;
      nxt_s.rdata = '0;
      if (rd_in || wr_in) begin
         nxt_s.resp = outcome;
         nxt_s.state = state;
      end
      if (wr_ok) begin
         case (grp)
            GRP_TRACE: begin
               if (addr_in == OFS_MAIN_CONTROL) begin
                  if (pd_set) begin
                     nxt_s.main_control[MC_PD_BIT] = wdata_in[MC_PD_BIT];
                  end else begin
                     nxt_s.main_control = wdata_in;
                  end
               end else if (!pd_set) begin
                  nxt_s.trace_data = wdata_in;
               end
            end
            GRP_LOCK_ACCESS: nxt_s.sw_lock = (wdata_in != UNLOCK_KEY);
            GRP_OS_LOCK_ACCESS: nxt_s.os_lock = wdata_in[OSL_BIT];
            GRP_OTHER_MGMT: nxt_s.claim = wdata_in;
            default: ;
         endcase
      end
      if (rd_ok) begin
         case (grp)
            GRP_TRACE: begin
               nxt_s.rdata = (addr_in == OFS_MAIN_CONTROL) ? s_ff.main_control : s_ff.trace_data;
            end
            GRP_LOCK_STATUS: begin
               nxt_s.rdata[LS_IMPL_BIT] = 1'b1;
               nxt_s.rdata[LS_LOCKED_BIT] = s_ff.sw_lock;
            end
            GRP_PD_STATUS: begin
               nxt_s.rdata[PDS_CORE_BIT] = ctx_in.core_power;
               nxt_s.rdata[PDS_STICKY_BIT] = s_ff.sticky;
               if (!s_ff.sw_lock) begin
                  nxt_s.sticky = 1'b0;
               end
            end
            GRP_OS_LOCK_STATUS: nxt_s.rdata[OSL_BIT] = s_ff.os_lock;
            GRP_ID: begin
               nxt_s.rdata = (addr_in == OFS_DEVICE_CFG_ID) ? DEVICE_CFG_ID_VAL : AUTH_STATUS_VAL;
            end
            GRP_OTHER_MGMT: nxt_s.rdata = s_ff.claim;
            default: nxt_s.rdata = '0;
         endcase
      end
      if (!ctx_in.core_power) begin
         nxt_s.sticky = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_ff <= REGS_RESET;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   assign rdata_out = s_ff.rdata;
   assign resp_out = s_ff.resp;
   assign resp_valid_out = s_ff.resp_valid;
   assign access_state_out = s_ff.state;
   assign main_control_out = s_ff.main_control;
   assign sw_lock_out = s_ff.sw_lock;
   assign os_lock_out = s_ff.os_lock;
   assign sticky_out = s_ff.sticky;

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);

   logic acc;
   logic powered;
   assign acc = rd_in || wr_in;
   assign powered = ctx_in.trace_power && ctx_in.core_power;

   a_no_debug_power:
   assert property (acc && !ctx_in.trace_power |=>
                    access_state_out == ST_NO_DEBUG_POWER && resp_out == OUT_ERROR)
      else $error("Access without debug power not refused.");

   a_mm_sw_disable:
   assert property (acc && path_in == PATH_MEMORY && !ctx_in.sw_debug_enable |=>
                    resp_valid_out && resp_out == OUT_ERROR)
      else $error("Memory access with software debug disabled not refused.");

   a_no_core_power:
   assert property (acc && path_in == PATH_DEBUGGER && ctx_in.trace_power &&
                    !ctx_in.core_power |=> access_state_out == ST_NO_CORE_POWER)
      else $error("No core power state missed.");

   a_cp_not_possible:
   assert property (rd_in && path_in == PATH_COPROC && ctx_in.trace_power &&
                    !ctx_in.core_power |=> resp_out == OUT_NPOSS ##0 rdata_out == '0)
      else $error("Coprocessor access without core power answered.");

   a_sticky_state:
   assert property (acc && path_in == PATH_DEBUGGER && powered && sticky_out |=>
                    access_state_out == ST_STICKY_SET)
      else $error("Sticky state not selected.");

   a_os_lock_state:
   assert property (acc && path_in == PATH_DEBUGGER && powered && !sticky_out &&
                    os_lock_out |=> access_state_out == ST_OS_LOCK_SET)
      else $error("OS lock state not selected.");

   a_nonpriv_wins:
   assert property (acc && path_in == PATH_COPROC && powered && ctx_in.nonpriv_mode &&
                    ctx_in.hyp_deny |=> access_state_out == ST_NON_PRIV && resp_out == OUT_ERROR)
      else $error("Non-privileged coprocessor access not refused.");

   a_otherwise_ok:
   assert property (rd_in && path_in == PATH_DEBUGGER && powered && !sticky_out &&
                    !os_lock_out && grp == GRP_TRACE |=>
                    access_state_out == ST_OTHERWISE && resp_out == OUT_OK)
      else $error("Unlocked trace read not accepted.");

   a_dbg_pd_status:
   assert property (rd_in && path_in == PATH_DEBUGGER && ctx_in.trace_power &&
                    grp == GRP_PD_STATUS |=> resp_out == OUT_OK)
      else $error("Debugger powerdown status read refused.");

   a_pd_write_mask:
   assert property (wr_in && addr_in == OFS_MAIN_CONTROL && main_control_out[MC_PD_BIT] |=>
                    $stable(main_control_out[DATA_W-1:1]))
      else $error("Main control written while powered down.");

   a_dbg_lock_wi:
   assert property (wr_in && path_in == PATH_DEBUGGER && grp == GRP_LOCK_ACCESS |=>
                    $stable(sw_lock_out))
      else $error("Debugger write changed the software lock.");

   a_cp_lock_wi:
   assert property (wr_in && path_in == PATH_COPROC && grp == GRP_LOCK_ACCESS |=>
                    $stable(sw_lock_out))
      else $error("Coprocessor write changed the software lock.");

   a_sticky_kept:
   assert property (rd_in && grp == GRP_PD_STATUS && sw_lock_out && sticky_out |=>
                    sticky_out)
      else $error("Sticky bit cleared under software lock.");

   a_swlock_wi:
   assert property (wr_in && path_in == PATH_MEMORY && powered && ctx_in.sw_debug_enable &&
                    sw_lock_out && grp == GRP_OS_LOCK_ACCESS |=>
                    resp_out == OUT_WI ##0 $stable(os_lock_out))
      else $error("Locked memory write not ignored.");

   a_error_discard:
   assert property (wr_in && outcome == OUT_ERROR |=> resp_out == OUT_ERROR &&
                    $stable(main_control_out) && $stable(os_lock_out) && $stable(sw_lock_out))
      else $error("Refused write changed a register.");

   a_ok_write:
   assert property (wr_in && outcome == OUT_OK && grp == GRP_OS_LOCK_ACCESS |=>
                    os_lock_out == $past(wdata_in[OSL_BIT]))
      else $error("Accepted OS lock write lost.");

   a_resp_follows:
   assert property (acc |=> resp_valid_out)
      else $error("Access not answered in the next cycle.");

   a_resp_quiet:
   assert property (!acc |=> !resp_valid_out)
      else $error("Answer given without an access.");

   a_refused_zero:
   assert property (rd_in && !rd_ok |=> rdata_out == '0)
      else $error("Refused read returned data.");

   a_sticky_set:
   assert property (!ctx_in.core_power |=> sticky_out)
      else $error("Sticky bit not set while the core is off.");

   a_trace_pd_drop:
   assert property (wr_in && addr_in == OFS_TRACE_DATA && main_control_out[MC_PD_BIT] |=>
                    $stable(s_ff.trace_data))
      else $error("Trace data written while powered down.");

   a_pd_bit_write:
   assert property (wr_ok && addr_in == OFS_MAIN_CONTROL |=>
                    main_control_out[MC_PD_BIT] == $past(wdata_in[MC_PD_BIT]))
      else $error("Powerdown bit write lost.");

   a_locked_read:
   assert property (rd_in && outcome == OUT_WI && grp == GRP_OTHER_MGMT |=>
                    rdata_out == $past(s_ff.claim))
      else $error("Locked read did not return the register value.");

   c_nonpriv: cover property (acc ##1 access_state_out == ST_NON_PRIV);
   c_unlock: cover property ($fell(sw_lock_out));
   c_sticky_clear: cover property ($fell(sticky_out));
   c_os_lock_set: cover property ($rose(os_lock_out) ##1 rd_in ##1 resp_out == OUT_ERROR);

endmodule

//--- hdl/trace_perm_pkg.sv
// Shared types, register offsets, field positions and reset values of the permission block.
package trace_perm_pkg;

   // ****************************************************************
   // Widths and carriers.
   // ****************************************************************
   localparam int DATA_W = 32;
   localparam int ADDR_W = 12;

   typedef logic [DATA_W-1:0] data_t;
   typedef logic [ADDR_W-1:0] addr_t;

   typedef enum logic [1:0] {PATH_DEBUGGER, PATH_MEMORY, PATH_COPROC} path_t;

   typedef enum logic [3:0] {
      GRP_TRACE, GRP_RES_TRACE, GRP_LOCK_STATUS, GRP_LOCK_ACCESS, GRP_PD_STATUS,
      GRP_OS_LOCK_STATUS, GRP_OS_LOCK_ACCESS, GRP_ID, GRP_OTHER_MGMT, GRP_RES_MGMT
   } group_t;

   typedef enum logic [2:0] {
      ST_NO_DEBUG_POWER, ST_NO_CORE_POWER, ST_NON_PRIV, ST_STICKY_SET, ST_OS_LOCK_SET,
      ST_OTHERWISE
   } access_state_t;

   typedef enum logic [2:0] {OUT_OK, OUT_ERROR, OUT_NPOSS, OUT_WI, OUT_RAZ, OUT_UNP} outcome_t;

   typedef struct packed {
      logic trace_power;
      logic core_power;
      logic sw_debug_enable;
      logic nonpriv_mode;
      logic coproc_deny;
      logic nonsecure_deny;
      logic hyp_deny;
   } power_ctx_t;

   // ****************************************************************
   // Register offsets.
   // ****************************************************************
   localparam addr_t OFS_MAIN_CONTROL = 12'h000;
   localparam addr_t OFS_TRACE_DATA = 12'h004;
   localparam addr_t OFS_MGMT_BASE = 12'h010;
   localparam addr_t OFS_LOCK_STATUS = 12'h010;
   localparam addr_t OFS_LOCK_ACCESS = 12'h014;
   localparam addr_t OFS_PD_STATUS = 12'h018;
   localparam addr_t OFS_OS_LOCK_STATUS = 12'h01C;
   localparam addr_t OFS_OS_LOCK_ACCESS = 12'h020;
   localparam addr_t OFS_DEVICE_CFG_ID = 12'h024;
   localparam addr_t OFS_AUTH_STATUS = 12'h028;
   localparam addr_t OFS_CLAIM = 12'h02C;

   // ****************************************************************
   // Field positions and values.
   // ****************************************************************
   localparam int MC_PD_BIT = 0;
   localparam int LS_IMPL_BIT = 0;
   localparam int LS_LOCKED_BIT = 1;
   localparam int PDS_CORE_BIT = 0;
   localparam int PDS_STICKY_BIT = 1;
   localparam int OSL_BIT = 0;

   localparam data_t MC_RESET = 32'h0000_0001;
   // The unlock key and both identity values are arbitrary.
   localparam data_t UNLOCK_KEY = 32'h0000_5A5A;
   localparam data_t DEVICE_CFG_ID_VAL = 32'h0000_0000;
   localparam data_t AUTH_STATUS_VAL = 32'h0000_0000;
   localparam logic SW_LOCK_RESET = 1'b1;
   localparam logic OS_LOCK_RESET = 1'b0;
   localparam logic STICKY_RESET = 1'b1;

   // Maps an address to its register group; unmapped space is reserved.
   function automatic group_t addr_group(input addr_t a);
      group_t g;
      g = (a < OFS_MGMT_BASE) ? GRP_RES_TRACE : GRP_RES_MGMT;
      case (a)
         OFS_MAIN_CONTROL, OFS_TRACE_DATA: g = GRP_TRACE;
         OFS_LOCK_STATUS: g = GRP_LOCK_STATUS;
         OFS_LOCK_ACCESS: g = GRP_LOCK_ACCESS;
         OFS_PD_STATUS: g = GRP_PD_STATUS;
         OFS_OS_LOCK_STATUS: g = GRP_OS_LOCK_STATUS;
         OFS_OS_LOCK_ACCESS: g = GRP_OS_LOCK_ACCESS;
         OFS_DEVICE_CFG_ID, OFS_AUTH_STATUS: g = GRP_ID;
         OFS_CLAIM: g = GRP_OTHER_MGMT;
         default: ;
      endcase
      return g;
   endfunction

endpackage

//--- hdl/access_perm_decode.sv
// Combinational access state and outcome decoder for one register access.
`timescale 1ns/1ps
module access_perm_decode (
   input wire trace_perm_pkg::power_ctx_t ctx_in,
   input wire trace_perm_pkg::path_t path_in,
   input wire trace_perm_pkg::group_t group_in,
   input wire logic sticky_in,
   input wire logic os_lock_in,
   input wire logic sw_lock_in,
   output trace_perm_pkg::access_state_t state_out,
   output trace_perm_pkg::outcome_t outcome_out
);
   import trace_perm_pkg::*;

   logic no_debug_power;
   logic no_core_power;
   logic non_priv;
   outcome_t general;

   // Groups that memory-mapped writes leave alone while the software lock is set.
   function automatic logic lock_marked(input group_t g);
      return (g == GRP_TRACE) || (g == GRP_OS_LOCK_ACCESS) || (g == GRP_OTHER_MGMT);
   endfunction

   // ****************************************************************
   // Access state by priority.
   // ****************************************************************
   assign no_debug_power = !ctx_in.trace_power ||
                           ((path_in == PATH_MEMORY) && !ctx_in.sw_debug_enable);
   assign no_core_power = !no_debug_power && !ctx_in.core_power;
   assign non_priv = (path_in == PATH_COPROC) && !no_debug_power && !no_core_power &&
                     ctx_in.nonpriv_mode &&
                     (ctx_in.coproc_deny || ctx_in.nonsecure_deny || ctx_in.hyp_deny);

   always_comb begin
      if (no_debug_power) begin
         state_out = ST_NO_DEBUG_POWER;
      end else if (no_core_power) begin
         state_out = ST_NO_CORE_POWER;
      end else if (non_priv) begin
         state_out = ST_NON_PRIV;
      end else if (sticky_in) begin
         state_out = ST_STICKY_SET;
      end else if (os_lock_in) begin
         state_out = ST_OS_LOCK_SET;
      end else begin
         state_out = ST_OTHERWISE;
      end
   end

   // ****************************************************************
   // Outcome per group and path.
   // ****************************************************************
   always_comb begin
      general = OUT_OK;
      case (group_in)
         GRP_TRACE: begin
            if (state_out inside {ST_NO_CORE_POWER, ST_STICKY_SET, ST_OS_LOCK_SET}) begin
               general = OUT_ERROR;
            end
         end
         GRP_RES_TRACE: begin
            general = ((path_in == PATH_COPROC) &&
                       (state_out inside {ST_STICKY_SET, ST_OS_LOCK_SET})) ? OUT_UNP : OUT_RAZ;
         end
         GRP_LOCK_STATUS: begin
            if (path_in != PATH_MEMORY) begin
               general = OUT_RAZ;
            end
         end
         GRP_LOCK_ACCESS: begin
            if (path_in != PATH_MEMORY) begin
               general = OUT_WI;
            end
         end
         GRP_RES_MGMT: general = OUT_RAZ;
         default: ;
      endcase
      if ((path_in == PATH_MEMORY) && sw_lock_in && lock_marked(group_in) &&
          (general == OUT_OK)) begin
         general = OUT_WI;
      end
      if (no_debug_power) begin
         outcome_out = OUT_ERROR;
      end else if (no_core_power && (path_in == PATH_COPROC)) begin
         outcome_out = OUT_NPOSS;
      end else if (non_priv) begin
         outcome_out = OUT_ERROR;
      end else begin
         outcome_out = general;
      end
   end

endmodule

//--- dv/reg_access_master.sv
// Behavioural master that issues register accesses on the three access paths.
`timescale 1ns/1ps
module reg_access_master (
   input wire logic clk_in,
   output trace_perm_pkg::power_ctx_t ctx_out,
   output trace_perm_pkg::path_t path_out,
   output trace_perm_pkg::addr_t addr_out,
   output trace_perm_pkg::data_t wdata_out,
   output logic wr_out,
   output logic rd_out,
   input wire trace_perm_pkg::data_t rdata_in,
   input wire trace_perm_pkg::outcome_t resp_in,
   input wire logic resp_valid_in
);
   import trace_perm_pkg::*;

   // ****************************************************************
   // Idle values.
   // ****************************************************************
   initial begin
      ctx_out = 7'h70;
      path_out = PATH_MEMORY;
      addr_out = 12'h000;
      wdata_out = 32'h0000_0000;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end

   // ****************************************************************
   // One access: one strobe cycle, answer taken in the cycle after.
   // ****************************************************************
   task automatic access(input power_ctx_t c, input path_t p, input logic w, input addr_t a,
         input data_t d, output outcome_t r, output data_t q, output logic v);
      @(posedge clk_in);
      ctx_out <= c;
      path_out <= p;
      addr_out <= a;
      wdata_out <= d;
      wr_out <= w;
      rd_out <= !w;
      @(posedge clk_in);
      wr_out <= 1'b0;
      rd_out <= 1'b0;
      // Released address and data lines show a changed value.
      addr_out <= ~a;
      wdata_out <= ~d;
      #1;
      r = resp_in;
      q = rdata_in;
      v = resp_valid_in;
   endtask
endmodule

//--- dv/test_trace_reg_access_permission_multi_power.sv
// Self-checking bench for the access-permission register block.
`timescale 1ns/1ps
module test_trace_reg_access_permission_multi_power;
   import trace_perm_pkg::*;

   // ****************************************************************
   // Contexts: bits are trace, core, swde, nonpriv, coproc, nonsec, hyp.
   // ****************************************************************
   localparam power_ctx_t PWR_ON = 7'h70;
   localparam power_ctx_t NO_SWDE = 7'h60;
   localparam power_ctx_t NO_TRACE = 7'h30;
   localparam power_ctx_t NO_CORE = 7'h50;
   localparam power_ctx_t NPRIV = 7'h78;
   localparam logic RD = 1'b0;
   localparam logic WR = 1'b1;

   logic clk_in;
   logic resetn_in;
   power_ctx_t ctx;
   path_t path;
   addr_t addr;
   data_t wdata;
   logic wr;
   logic rd;
   data_t rdata;
   outcome_t resp;
   logic resp_valid;
   access_state_t st;
   data_t mc;
   logic sw_lock;
   logic os_lock;
   logic sticky;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;
   data_t rd_val;
   addr_t mem_addrs[7] = '{12'h000, 12'h008, 12'h010, 12'h014, 12'h018, 12'h02C, 12'h030};

   trace_reg_access_permission_multi_power DUT (.clk_in(clk_in), .resetn_in(resetn_in),
      .ctx_in(ctx), .path_in(path), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata), .resp_out(resp), .resp_valid_out(resp_valid),
      .access_state_out(st), .main_control_out(mc), .sw_lock_out(sw_lock),
      .os_lock_out(os_lock), .sticky_out(sticky));

   reg_access_master M (.clk_in(clk_in), .ctx_out(ctx), .path_out(path), .addr_out(addr),
      .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .rdata_in(rdata), .resp_in(resp),
      .resp_valid_in(resp_valid));

   // ****************************************************************
   // Clock, timeout and reporting.
   // ****************************************************************
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   task automatic finish_test();
      if (failures == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures = failures + 1;
         finish_test();
      end
   end

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic xfer(input power_ctx_t c, input path_t p, input logic w, input addr_t a,
         input data_t d, input outcome_t eo, input access_state_t es);
      outcome_t r;
      logic v;
      M.access(c, p, w, a, d, r, rd_val, v);
      check("resp_valid_out", 1'b1, v);
      check("resp_out", eo, r);
      check("access_state_out", es, st);
   endtask

   // ****************************************************************
   // Test sequence.
   // ****************************************************************
   initial begin
      resetn_in = 1'b0;
      repeat (16) @(posedge clk_in);
      resetn_in <= 1'b1;
      check("main_control_out", MC_RESET, mc);
      check("sw_lock_out", SW_LOCK_RESET, sw_lock);
      check("os_lock_out", OS_LOCK_RESET, os_lock);
      check("sticky_out", STICKY_RESET, sticky);
      check("access_state_out", ST_OTHERWISE, st);
      foreach (mem_addrs[i]) begin
         xfer(NO_SWDE, PATH_MEMORY, RD, mem_addrs[i], '0, OUT_ERROR, ST_NO_DEBUG_POWER);
         check("rdata_out", 32'h0000_0000, rd_val);
      end
      xfer(NO_SWDE, PATH_MEMORY, WR, 12'h000, '0, OUT_ERROR, ST_NO_DEBUG_POWER);
      check("main_control_out", MC_RESET, mc);
      xfer(NO_SWDE, PATH_DEBUGGER, RD, 12'h018, '0, OUT_OK, ST_STICKY_SET);
      check("rdata_out", 32'h0000_0003, rd_val);
      xfer(NO_TRACE, PATH_DEBUGGER, RD, 12'h018, '0, OUT_ERROR, ST_NO_DEBUG_POWER);
      xfer(NO_TRACE, PATH_COPROC, RD, 12'h02C, '0, OUT_ERROR, ST_NO_DEBUG_POWER);
      xfer(NO_CORE, PATH_DEBUGGER, RD, 12'h000, '0, OUT_ERROR, ST_NO_CORE_POWER);
      xfer(NO_CORE, PATH_DEBUGGER, RD, 12'h010, '0, OUT_RAZ, ST_NO_CORE_POWER);
      check("rdata_out", 32'h0000_0000, rd_val);
      xfer(NO_CORE, PATH_DEBUGGER, RD, 12'h018, '0, OUT_OK, ST_NO_CORE_POWER);
      check("rdata_out", 32'h0000_0002, rd_val);
      xfer(NO_CORE, PATH_COPROC, RD, 12'h02C, '0, OUT_NPOSS, ST_NO_CORE_POWER);
      xfer(PWR_ON, PATH_DEBUGGER, RD, 12'h004, '0, OUT_ERROR, ST_STICKY_SET);
      xfer(PWR_ON, PATH_MEMORY, RD, 12'h018, '0, OUT_OK, ST_STICKY_SET);
      check("sticky_out", 1'b1, sticky);
      xfer(PWR_ON, PATH_MEMORY, WR, 12'h014, UNLOCK_KEY, OUT_OK, ST_STICKY_SET);
      check("sw_lock_out", 1'b0, sw_lock);
      xfer(PWR_ON, PATH_DEBUGGER, WR, 12'h014, '0, OUT_WI, ST_STICKY_SET);
      check("sw_lock_out", 1'b0, sw_lock);
      xfer(PWR_ON, PATH_COPROC, WR, 12'h014, '0, OUT_WI, ST_STICKY_SET);
      check("sw_lock_out", 1'b0, sw_lock);
      xfer(PWR_ON, PATH_MEMORY, RD, 12'h018, '0, OUT_OK, ST_STICKY_SET);
      check("sticky_out", 1'b0, sticky);
      xfer(PWR_ON, PATH_DEBUGGER, RD, 12'h000, '0, OUT_OK, ST_OTHERWISE);
      check("rdata_out", MC_RESET, rd_val);
      xfer(PWR_ON, PATH_DEBUGGER, WR, 12'h004, 32'h0000_0077, OUT_OK, ST_OTHERWISE);
      xfer(PWR_ON, PATH_DEBUGGER, RD, 12'h004, '0, OUT_OK, ST_OTHERWISE);
      check("rdata_out", 32'h0000_0000, rd_val);
      xfer(PWR_ON, PATH_DEBUGGER, WR, 12'h000, 32'hFFFF_FFFE, OUT_OK, ST_OTHERWISE);
      check("main_control_out", 32'h0000_0000, mc);
      xfer(PWR_ON, PATH_DEBUGGER, WR, 12'h004, 32'h0000_0077, OUT_OK, ST_OTHERWISE);
      xfer(PWR_ON, PATH_DEBUGGER, RD, 12'h004, '0, OUT_OK, ST_OTHERWISE);
      check("rdata_out", 32'h0000_0077, rd_val);
      xfer(PWR_ON, PATH_MEMORY, WR, 12'h01C, 32'h0000_0001, OUT_OK, ST_OTHERWISE);
      check("os_lock_out", 1'b0, os_lock);
      xfer(PWR_ON, PATH_MEMORY, RD, 12'h020, '0, OUT_OK, ST_OTHERWISE);
      check("rdata_out", 32'h0000_0000, rd_val);
      xfer(PWR_ON, PATH_MEMORY, RD, 12'h024, '0, OUT_OK, ST_OTHERWISE);
      check("rdata_out", DEVICE_CFG_ID_VAL, rd_val);
      xfer(PWR_ON, PATH_MEMORY, WR, 12'h02C, 32'h0000_00A5, OUT_OK, ST_OTHERWISE);
      xfer(PWR_ON, PATH_MEMORY, WR, 12'h020, 32'h0000_0001, OUT_OK, ST_OTHERWISE);
      check("os_lock_out", 1'b1, os_lock);
      xfer(PWR_ON, PATH_DEBUGGER, RD, 12'h004, '0, OUT_ERROR, ST_OS_LOCK_SET);
      xfer(PWR_ON, PATH_COPROC, RD, 12'h02C, '0, OUT_OK, ST_OS_LOCK_SET);
      xfer(PWR_ON, PATH_COPROC, RD, 12'h000, '0, OUT_ERROR, ST_OS_LOCK_SET);
      xfer(PWR_ON, PATH_COPROC, RD, 12'h008, '0, OUT_UNP, ST_OS_LOCK_SET);
      for (int i = 0; i < 3; i++) begin
         xfer(NPRIV | (7'h04 >> i), PATH_COPROC, RD, 12'h02C, '0, OUT_ERROR, ST_NON_PRIV);
      end
      xfer(NPRIV, PATH_COPROC, RD, 12'h02C, '0, OUT_OK, ST_OS_LOCK_SET);
      xfer(NPRIV | 7'h04, PATH_DEBUGGER, RD, 12'h018, '0, OUT_OK, ST_OS_LOCK_SET);
      xfer(PWR_ON, PATH_MEMORY, WR, 12'h014, '0, OUT_OK, ST_OS_LOCK_SET);
      check("sw_lock_out", 1'b1, sw_lock);
      xfer(PWR_ON, PATH_MEMORY, WR, 12'h020, '0, OUT_WI, ST_OS_LOCK_SET);
      check("os_lock_out", 1'b1, os_lock);
      xfer(PWR_ON, PATH_MEMORY, RD, 12'h01C, '0, OUT_OK, ST_OS_LOCK_SET);
      check("rdata_out", 32'h0000_0001, rd_val);
      xfer(PWR_ON, PATH_MEMORY, WR, 12'h02C, 32'h0000_0055, OUT_WI, ST_OS_LOCK_SET);
      xfer(PWR_ON, PATH_MEMORY, RD, 12'h02C, '0, OUT_WI, ST_OS_LOCK_SET);
      check("rdata_out", 32'h0000_00A5, rd_val);
      finish_test();
   end
endmodule
